// >>> verilog/ucuc_params.svh
/*
 Offsets, field positions and reset values for the upper command controls.
 Assumes inclusion by bare name from the package and the top module.
*/
`ifndef UCUC_PARAMS_SVH
`define UCUC_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define UCUC_CMD_OFFSET 8'h00
`define UCUC_STS_OFFSET 8'h04
`define UCUC_IEN_OFFSET 8'h08
`define UCUC_CTL_OFFSET 8'h0C

// ----------------------------------------
// Command register field positions
// ----------------------------------------
`define UCUC_FLS_MSB_BIT 15
`define UCUC_ADD_TW_BIT 14
`define UCUC_SETUP_TW_BIT 13
`define UCUC_PARK_EN_BIT 11
`define UCUC_PARK_CNT_HI 9
`define UCUC_PARK_CNT_LO 8
`define UCUC_LIGHT_RST_BIT 7
`define UCUC_DOORBELL_BIT 6
`define UCUC_FLS_LOW_HI 3
`define UCUC_FLS_LOW_LO 2

// ----------------------------------------
// Status, enable and control fields
// ----------------------------------------
`define UCUC_STS_ADV_BIT 5
`define UCUC_CTL_THR_HI 7
`define UCUC_CTL_THR_LO 0

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define UCUC_PARK_CNT_RST 2'h0
`define UCUC_FLS_RST 3'h0
`define UCUC_FLS_MAX_ENTRIES 11'h400
`define UCUC_THR_RST 8'h08

`endif

// >>> verilog/ucuc_pkg.sv
/*
 Types shared by the upper command controls design.
 Assumes the params header is on the include path.
*/
package ucuc_pkg;
`include "ucuc_params.svh"

	// ----------------------------------------
	// Bus request carrier
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ucuc_bus_t;

	// ----------------------------------------
	// Engine hazard and event carrier
	// ----------------------------------------
	typedef struct packed {
		logic add_hazard;
		logic setup_arrive;
		logic setup_lockout;
		logic evict_done;
		logic frame_tick;
	} ucuc_evt_t;

	typedef enum logic [1:0] {
		UCUC_DB_IDLE,
		UCUC_DB_WAIT,
		UCUC_DB_FLAG
	} ucuc_db_state_t;

endpackage : ucuc_pkg

// >>> verilog/ucuc_flag.sv
/*
 Sticky flag: software sets or clears, hardware clears; hardware clear wins.
 Assumes all inputs are synchronous to the clock.
*/
module ucuc_flag
	import ucuc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sw_wr,
	input wire logic sw_val,
	input wire logic hw_clr,
	output logic q
);
	logic next_q;

	// Hazard clear beats a software write in the same cycle so the hazard is never missed
	assign next_q = hw_clr ? 1'b0 : (sw_wr ? sw_val : q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	hw_clear_a: assert property (@(posedge clk) disable iff (rst) hw_clr |=> !q)
		else $error("tripwire not cleared by hazard");
endmodule : ucuc_flag

// >>> verilog/ucuc_thresh.sv
/*
 Interrupt threshold counter: counts frame ticks, pulses at each boundary.
 Assumes frame ticks are single-cycle pulses on the system clock.
*/
module ucuc_thresh
	import ucuc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic [7:0] limit,
	output logic boundary
);
	logic [7:0] cnt;
	logic next_boundary;
	logic wrap;

	// A zero limit means no threshold: every tick is a boundary
	assign wrap = tick && ((limit == 8'h00) || (cnt + 8'h01 >= limit));
	assign next_boundary = wrap;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			boundary <= 1'b0;
		end else begin
			boundary <= next_boundary;
			if (wrap) begin
				cnt <= 8'h00;
			end else if (tick) begin
				cnt <= cnt + 8'h01;
			end
		end
	end

	boundary_pulse_a: assert property (@(posedge clk) disable iff (rst) boundary |=> !boundary || $past(tick))
		else $error("threshold boundary without tick");
endmodule : ucuc_thresh

// >>> verilog/ucuc_top.sv
/*
 Upper controls of the command register: tripwires, park mode, doorbell.
 Assumes a plain register port on SYS_CLK and engine events on SYS_CLK.
*/
// Local design decisions: strobed register access and the register addresses.
// Overview of operation
// - Software reads and writes the descriptor-add tripwire at bit 14.
// - Hardware clears the descriptor-add tripwire on an endpoint hazard window.
// - Software reads and writes the setup tripwire at bit 13.
// - With lockout off, new setup arrival clears the setup tripwire.
// - Park enable at bit 11 is read/write, resets to zero.
// - Park count at bits 9..8 resets to zero, limits queue head transactions.
// - Light reset bit 7 is unimplemented and reads zero.
// - After eviction completes, hardware sets the async-advance status flag.
// - With enable set, interrupt rises at next threshold boundary after flag.
// - Doorbell clears only after the async-advance flag is set.
// - Bit 15 is the frame list size most significant bit.
// - Frame list size halves from 1024 entries at 000 to 8 at 111.
`include "ucuc_params.svh"

module ucuc_top
	import ucuc_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic ADD_HAZARD,
	input wire logic SETUP_ARRIVE,
	input wire logic SETUP_LOCKOUT,
	input wire logic EVICT_DONE,
	input wire logic FRAME_TICK,
	output logic PARK_ENABLE,
	output logic [1:0] PARK_COUNT,
	output logic [10:0] FRAME_LIST_ENTRIES,
	output logic DOORBELL_REQ,
	output logic ASYNC_ADV_IRQ
);
	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	ucuc_bus_t bus;
	ucuc_evt_t evt;
	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	assign evt = '{add_hazard: ADD_HAZARD, setup_arrive: SETUP_ARRIVE,
		setup_lockout: SETUP_LOCKOUT, evict_done: EVICT_DONE, frame_tick: FRAME_TICK};

	wire cmd_wr = bus.wr && (bus.addr == `UCUC_CMD_OFFSET);
	wire sts_wr = bus.wr && (bus.addr == `UCUC_STS_OFFSET);
	wire ien_wr = bus.wr && (bus.addr == `UCUC_IEN_OFFSET);
	wire ctl_wr = bus.wr && (bus.addr == `UCUC_CTL_OFFSET);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic add_tw;
	logic setup_tw;
	logic park_en;
	logic [1:0] park_cnt;
	logic [2:0] fls;
	logic adv_flag;
	logic adv_en;
	logic [7:0] thr;
	logic doorbell;
	logic irq;
	logic boundary;
	logic [31:0] rd_word;
	ucuc_db_state_t db_state;
	ucuc_db_state_t next_db_state;

	// ----------------------------------------
	// Tripwires
	// ----------------------------------------
	wire setup_hazard = evt.setup_arrive && !evt.setup_lockout;

	ucuc_flag u_add_tw (
		.clk(SYS_CLK),
		.rst(RESET),
		.sw_wr(cmd_wr),
		.sw_val(bus.wdata[`UCUC_ADD_TW_BIT]),
		.hw_clr(evt.add_hazard),
		.q(add_tw)
	);

	ucuc_flag u_setup_tw (
		.clk(SYS_CLK),
		.rst(RESET),
		.sw_wr(cmd_wr),
		.sw_val(bus.wdata[`UCUC_SETUP_TW_BIT]),
		.hw_clr(setup_hazard),
		.q(setup_tw)
	);

	// ----------------------------------------
	// Park mode and frame list size
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			park_en <= 1'b0;
			park_cnt <= `UCUC_PARK_CNT_RST;
			fls <= `UCUC_FLS_RST;
		end else if (cmd_wr) begin
			park_en <= bus.wdata[`UCUC_PARK_EN_BIT];
			park_cnt <= bus.wdata[`UCUC_PARK_CNT_HI:`UCUC_PARK_CNT_LO];
			fls <= {bus.wdata[`UCUC_FLS_MSB_BIT],
				bus.wdata[`UCUC_FLS_LOW_HI:`UCUC_FLS_LOW_LO]};
		end
	end

	// Zero count with park enabled is left to software to avoid; passed on as is
	assign PARK_ENABLE = park_en;
	assign PARK_COUNT = park_cnt;
	assign FRAME_LIST_ENTRIES = `UCUC_FLS_MAX_ENTRIES >> fls;

	// ----------------------------------------
	// Doorbell sequence
	// ----------------------------------------
	wire ring = cmd_wr && bus.wdata[`UCUC_DOORBELL_BIT];

	always_comb begin
		next_db_state = db_state;
		case (db_state)
			UCUC_DB_IDLE: begin
				if (ring) begin
					next_db_state = UCUC_DB_WAIT;
				end
			end
			UCUC_DB_WAIT: begin
				if (evt.evict_done) begin
					next_db_state = UCUC_DB_FLAG;
				end
			end
			UCUC_DB_FLAG: begin
				next_db_state = UCUC_DB_IDLE;
			end
			default: begin
				next_db_state = UCUC_DB_IDLE;
			end
		endcase
	end

	wire flag_set = (db_state == UCUC_DB_WAIT) && evt.evict_done;
	// Write one to clear; a set in the same cycle wins
	wire flag_clr = sts_wr && bus.wdata[`UCUC_STS_ADV_BIT];

	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			db_state <= UCUC_DB_IDLE;
			adv_flag <= 1'b0;
		end else begin
			db_state <= next_db_state;
			adv_flag <= flag_set | (adv_flag & ~flag_clr);
		end
	end

	// Doorbell stays high through the flag cycle, drops the cycle after
	assign doorbell = (db_state != UCUC_DB_IDLE);
	assign DOORBELL_REQ = doorbell;

	// ----------------------------------------
	// Interrupt enable, threshold, interrupt
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			adv_en <= 1'b0;
			thr <= `UCUC_THR_RST;
		end else begin
			if (ien_wr) begin
				adv_en <= bus.wdata[`UCUC_STS_ADV_BIT];
			end
			if (ctl_wr) begin
				thr <= bus.wdata[`UCUC_CTL_THR_HI:`UCUC_CTL_THR_LO];
			end
		end
	end

	ucuc_thresh u_thresh (
		.clk(SYS_CLK),
		.rst(RESET),
		.tick(evt.frame_tick),
		.limit(thr),
		.boundary(boundary)
	);

	// Interrupt latched at a boundary, held until the flag or enable drops
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			irq <= 1'b0;
		end else if (!(adv_flag && adv_en)) begin
			irq <= 1'b0;
		end else if (boundary) begin
			irq <= 1'b1;
		end
	end
	assign ASYNC_ADV_IRQ = irq;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [31:0] cmd_word;
	always_comb begin
		cmd_word = 32'h0000_0000;
		cmd_word[`UCUC_FLS_MSB_BIT] = fls[2];
		cmd_word[`UCUC_ADD_TW_BIT] = add_tw;
		cmd_word[`UCUC_SETUP_TW_BIT] = setup_tw;
		cmd_word[`UCUC_PARK_EN_BIT] = park_en;
		cmd_word[`UCUC_PARK_CNT_HI:`UCUC_PARK_CNT_LO] = park_cnt;
		cmd_word[`UCUC_LIGHT_RST_BIT] = 1'b0;
		cmd_word[`UCUC_DOORBELL_BIT] = doorbell;
		cmd_word[`UCUC_FLS_LOW_HI:`UCUC_FLS_LOW_LO] = fls[1:0];
	end

	assign rd_word = (bus.addr == `UCUC_CMD_OFFSET) ? cmd_word :
		(bus.addr == `UCUC_STS_OFFSET) ? {26'h0, adv_flag, 5'h00} :
		(bus.addr == `UCUC_IEN_OFFSET) ? {26'h0, adv_en, 5'h00} :
		(bus.addr == `UCUC_CTL_OFFSET) ? {24'h00_0000, thr} : 32'h0000_0000;

	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= 32'h0000_0000;
		end else begin
			RDATA <= bus.rd ? rd_word : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	light_reset_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		$past(bus.rd) |-> !RDATA[`UCUC_LIGHT_RST_BIT]) else $error("light reset bit read one");
	reserved_zero_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		$past(bus.rd) |-> (RDATA[12] == 1'b0 && RDATA[10] == 1'b0))
		else $error("reserved bit read one");
	setup_hazard_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(SETUP_ARRIVE && !SETUP_LOCKOUT) |=> !setup_tw) else $error("setup tripwire kept");
	add_hazard_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		ADD_HAZARD |=> !add_tw) else $error("add tripwire kept");
	park_write_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		cmd_wr |=> (PARK_ENABLE == $past(WDATA[11]) && PARK_COUNT == $past(WDATA[9:8])))
		else $error("park fields not written");
	adv_set_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(db_state == UCUC_DB_WAIT && EVICT_DONE) |=> adv_flag) else $error("advance flag not set");
	// The flag is set on the edge that enters the flag state, so it is already up when the bell drops
	bell_order_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		$fell(doorbell) |-> adv_flag) else $error("doorbell cleared before flag");
	bell_flag_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(db_state == UCUC_DB_FLAG) |-> (doorbell && adv_flag))
		else $error("doorbell state without flag");
	bell_start_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(ring && db_state == UCUC_DB_IDLE) |=> doorbell) else $error("doorbell not raised");
	irq_drop_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		!(adv_flag && adv_en) |=> !irq) else $error("interrupt kept without cause");
	thr_write_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		ctl_wr |=> (thr == $past(WDATA[7:0]))) else $error("threshold not written");
	// A software write only lands when no hazard clears the same tripwire
	add_write_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(cmd_wr && !ADD_HAZARD) |=> (add_tw == $past(WDATA[14])))
		else $error("add tripwire not written");
	setup_write_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(cmd_wr && !setup_hazard) |=> (setup_tw == $past(WDATA[13])))
		else $error("setup tripwire not written");
	park_hold_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		!cmd_wr |=> $stable(park_en)) else $error("park enable changed without write");
	fls_read_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		$past(bus.rd && bus.addr == `UCUC_CMD_OFFSET) |-> ({RDATA[15], RDATA[3:2]} == $past(fls)))
		else $error("frame list size read wrong");
	// Read data stand for one cycle only, so stale words never reach software
	rdata_idle_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		!$past(bus.rd) |-> (RDATA == 32'h0000_0000)) else $error("read data outside read");
	irq_cause_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		$rose(irq) |-> $past(boundary && adv_flag && adv_en)) else $error("interrupt without cause");
	fls_size_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(fls == 3'h7) |-> (FRAME_LIST_ENTRIES == 11'h008)) else $error("frame list size wrong");

	ring_c: cover property (@(posedge SYS_CLK) disable iff (RESET) ring ##[1:20] flag_set);
	irq_c: cover property (@(posedge SYS_CLK) disable iff (RESET) $rose(irq));
	setup_c: cover property (@(posedge SYS_CLK) disable iff (RESET) setup_tw && setup_hazard);
	add_c: cover property (@(posedge SYS_CLK) disable iff (RESET) add_tw && evt.add_hazard);
	park_c: cover property (@(posedge SYS_CLK) disable iff (RESET) park_en && park_cnt == 2'h3);
endmodule : ucuc_top

// >>> tb/ucuc_engine_model.sv
/*
 Behavioural model of the schedule engine beside the command controls.
 Assumes the doorbell level from the block and one system clock.
*/
module ucuc_engine_model
	import ucuc_pkg::*;
#(
	parameter int TICK_GAP = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic doorbell_req,
	input wire logic [3:0] evict_delay,
	output logic evict_done,
	output logic frame_tick
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] tick_cnt;
	logic [3:0] wait_cnt;
	logic busy;
	logic done_seen;

	// ----------------------------------------
	// Microframe ticks and cache eviction
	// ----------------------------------------
	// One eviction per request; the model re-arms only after the doorbell drops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= '0;
			wait_cnt <= '0;
			busy <= 1'b0;
			done_seen <= 1'b0;
			evict_done <= 1'b0;
			frame_tick <= 1'b0;
		end else begin
			tick_cnt <= (tick_cnt == 4'(TICK_GAP - 1)) ? 4'h0 : tick_cnt + 4'h1;
			frame_tick <= (tick_cnt == 4'(TICK_GAP - 1));
			evict_done <= 1'b0;
			if (!doorbell_req) begin
				done_seen <= 1'b0;
			end else if (!busy && !done_seen) begin
				busy <= 1'b1;
				wait_cnt <= evict_delay;
			end else if (busy && wait_cnt == 4'h0) begin
				busy <= 1'b0;
				done_seen <= 1'b1;
				evict_done <= 1'b1;
			end else if (busy) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end
	end
endmodule : ucuc_engine_model

// >>> tb/testbench.sv
/*
 Self-checking bench for the upper command controls.
 Assumes the engine model supplies eviction and ticks; the bench drives the rest.
*/
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module testbench;
	import ucuc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic SYS_CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0000_0000, RDATA;
	logic ADD_HAZARD = 1'b0, SETUP_ARRIVE = 1'b0, SETUP_LOCKOUT = 1'b0;
	logic EVICT_DONE, FRAME_TICK, PARK_ENABLE, DOORBELL_REQ, ASYNC_ADV_IRQ;
	logic [1:0] PARK_COUNT;
	logic [10:0] FRAME_LIST_ENTRIES;
	logic [3:0] evict_delay = 4'h1;
	int err_count = 0, checks = 0;

	ucuc_top ucuc_top_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .ADD_HAZARD(ADD_HAZARD),
		.SETUP_ARRIVE(SETUP_ARRIVE), .SETUP_LOCKOUT(SETUP_LOCKOUT),
		.EVICT_DONE(EVICT_DONE), .FRAME_TICK(FRAME_TICK), .PARK_ENABLE(PARK_ENABLE),
		.PARK_COUNT(PARK_COUNT), .FRAME_LIST_ENTRIES(FRAME_LIST_ENTRIES),
		.DOORBELL_REQ(DOORBELL_REQ), .ASYNC_ADV_IRQ(ASYNC_ADV_IRQ));

	ucuc_engine_model #(.TICK_GAP(8)) ucuc_engine_model_inst (.clk(SYS_CLK), .rst(RESET),
		.doorbell_req(DOORBELL_REQ), .evict_delay(evict_delay),
		.evict_done(EVICT_DONE), .frame_tick(FRAME_TICK));

	initial begin
		forever #25 SYS_CLK = ~SYS_CLK;
	end

	// ----------------------------------------
	// Register port tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK) begin WR <= 1'b1; ADDR <= a; WDATA <= d; end
		@(posedge SYS_CLK) WR <= 1'b0;
		#1;
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge SYS_CLK) begin RD <= 1'b1; ADDR <= a; end
		@(posedge SYS_CLK) RD <= 1'b0;
		#1 `CHK(RDATA, e)
	endtask : rdchk

	task automatic finish_test;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	// Bounded wait for a level; a timeout counts as a mismatch
	task automatic wait_lvl(ref logic s, input logic v);
		int n;
		for (n = 0; n < 60 && s !== v; n++) begin
			@(posedge SYS_CLK);
			#1;
		end
		if (s !== v) begin
			err_count++;
			finish_test();
		end
	endtask : wait_lvl

	// ----------------------------------------
	// Doorbell round trip
	// ----------------------------------------
	// Schedule taken as active and host mode, since the doorbell is undefined otherwise
	task automatic ring(input logic [3:0] dly);
		evict_delay = dly;
		wr(8'h00, 32'h0000_0040);
		`CHK(DOORBELL_REQ, 1'b1)
		wait_lvl(DOORBELL_REQ, 1'b0);
		rdchk(8'h04, 32'h0000_0020);
		rdchk(8'h00, 32'h0000_0000);
	endtask : ring

	initial begin
		repeat (16) @(posedge SYS_CLK);
		RESET <= 1'b0;
		rdchk(8'h00, 32'h0000_0000);
		`CHK(FRAME_LIST_ENTRIES, 11'h400)
		wr(8'h00, 32'hFFFF_FFBF);
		rdchk(8'h00, 32'h0000_EB0C);
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, {16'h0, i[2], 11'h0, i[1:0], 2'h0});
			`CHK(FRAME_LIST_ENTRIES, 11'h400 >> i)
		end
		// Only counts 1..3 while parked; enable is dropped by the same write that zeroes the count
		for (int i = 1; i < 4; i++) begin
			wr(8'h00, {20'h0, 4'h8 | 4'(i), 8'h0});
			`CHK(PARK_COUNT, i[1:0])
			`CHK(PARK_ENABLE, 1'b1)
		end
		wr(8'h00, 32'h0000_0000);
		`CHK(PARK_ENABLE, 1'b0)
		wr(8'h00, 32'h0000_6000);
		@(posedge SYS_CLK) ADD_HAZARD <= 1'b1;
		@(posedge SYS_CLK) ADD_HAZARD <= 1'b0;
		rdchk(8'h00, 32'h0000_2000);
		@(posedge SYS_CLK) begin SETUP_LOCKOUT <= 1'b1; SETUP_ARRIVE <= 1'b1; end
		@(posedge SYS_CLK) SETUP_ARRIVE <= 1'b0;
		rdchk(8'h00, 32'h0000_2000);
		@(posedge SYS_CLK) begin SETUP_LOCKOUT <= 1'b0; SETUP_ARRIVE <= 1'b1; end
		@(posedge SYS_CLK) SETUP_ARRIVE <= 1'b0;
		rdchk(8'h00, 32'h0000_0000);
		wr(8'h00, 32'h0000_6000);
		wr(8'h00, 32'h0000_0000);
		rdchk(8'h00, 32'h0000_0000);
		wr(8'hF0, 32'hFFFF_FFFF);
		rdchk(8'hF0, 32'h0000_0000);
		wr(8'h0C, 32'h0000_0001);
		wr(8'h08, 32'h0000_0020);
		ring(4'h1);
		wait_lvl(ASYNC_ADV_IRQ, 1'b1);
		wr(8'h04, 32'h0000_0020);
		@(posedge SYS_CLK);
		#1 `CHK(ASYNC_ADV_IRQ, 1'b0)
		wr(8'h08, 32'h0000_0000);
		ring(4'hF);
		repeat (30) @(posedge SYS_CLK);
		#1 `CHK(ASYNC_ADV_IRQ, 1'b0)
		wr(8'h08, 32'h0000_0020);
		wait_lvl(ASYNC_ADV_IRQ, 1'b1);
		finish_test();
	end
endmodule : testbench
